// >>> hw/pmc_pkg.sv
// Constants, field positions and carrier types for the power management capability block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses and a single clock.
package pmc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_CAPS        = 8'h70;
    localparam logic [7:0]  OFS_CSR         = 8'h74;

    // ----------------------------------------------------------------
    // Capabilities word fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  CAP_ID_VAL      = 8'h01;
    localparam logic [7:0]  NEXT_PTR_A      = 8'h00;
    localparam logic [7:0]  NEXT_PTR_BC     = 8'h7c;
    localparam logic [2:0]  CAP_VERSION     = 3'h2;
    localparam logic [4:0]  WAKE_SUPPORT    = 5'h19;
    localparam int          DEV_INIT_BIT    = 21;
    localparam logic        DEV_INIT_RST    = 1'h0;

    // ----------------------------------------------------------------
    // Control and status word fields
    // ----------------------------------------------------------------
    localparam int          WAKE_EN_BIT     = 8;
    localparam int          WAKE_STS_BIT    = 15;
    localparam logic [1:0]  POWER_STATE_FIELD_D0       = 2'h0;
    localparam logic [1:0]  POWER_STATE_FIELD_D3HOT    = 2'h3;
    localparam logic        WAKE_EN_RST     = 1'h0;
    localparam logic        WAKE_STS_RST    = 1'h0;

    // ----------------------------------------------------------------
    // Bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
        logic [3:0]        strb;
    } pmc_wr_s;

    typedef struct packed {
        logic own;
        logic fwd;
        logic enable;
        logic d3cold;
    } pmc_wake_req_s;

    function automatic logic pmc_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFS_CAPS) || (a == OFS_CSR);
    endfunction : pmc_mapped

endpackage : pmc_pkg

// >>> hw/pmc_axil.sv
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes read data for the presented read address is supplied combinationally by the parent.
module pmc_axil (
    input  wire logic                      mclk,     // Clock.
    input  wire logic                      srst,     // Synchronous reset.
    input  wire logic [pmc_pkg::ADDR_W-1:0] awaddr,  // Write address.
    input  wire logic                      awvalid,  // Write address valid.
    output logic                           awready,  // Write address ready.
    input  wire logic [31:0]               wdata,    // Write data.
    input  wire logic [3:0]                wstrb,    // Write byte strobes.
    input  wire logic                      wvalid,   // Write data valid.
    output logic                           wready,   // Write data ready.
    output logic [1:0]                     bresp,    // Write response.
    output logic                           bvalid,   // Write response valid.
    input  wire logic                      bready,   // Write response ready.
    input  wire logic [pmc_pkg::ADDR_W-1:0] araddr,  // Read address.
    input  wire logic                      arvalid,  // Read address valid.
    output logic                           arready,  // Read address ready.
    output logic [31:0]                    rdata,    // Read data.
    output logic [1:0]                     rresp,    // Read response.
    output logic                           rvalid,   // Read data valid.
    input  wire logic                      rready,   // Read data ready.
    input  wire logic [31:0]               rd_word,  // Read value for araddr.
    output pmc_pkg::pmc_wr_s               wr        // Write commit, one cycle.
);
    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      aw_full;
        logic                      w_full;
        logic [pmc_pkg::ADDR_W-1:0] addr;
        logic [31:0]               data;
        logic [3:0]                strb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } pmc_axil_s;

    pmc_axil_s s_q;
    pmc_axil_s s_d;
    logic      commit;

    assign commit   = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign wr.en    = commit;
    assign wr.addr  = s_q.addr;
    assign wr.data  = s_q.data;
    assign wr.strb  = s_q.strb;
    assign awready  = s_q.awready;
    assign wready   = s_q.wready;
    assign bvalid   = s_q.bvalid;
    assign bresp    = s_q.bresp;
    assign arready  = s_q.arready;
    assign rvalid   = s_q.rvalid;
    assign rdata    = s_q.rdata;
    assign rresp    = s_q.rresp;

    always_comb begin
        s_d = s_q;
        if (awvalid && s_q.awready) begin
            s_d.aw_full = 1'b1;
            s_d.awready = 1'b0;
            s_d.addr    = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_full = 1'b1;
            s_d.wready = 1'b0;
            s_d.data   = wdata;
            s_d.strb   = wstrb;
        end
        if (commit) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = pmc_pkg::pmc_mapped(s_q.addr) ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid  = 1'b0;
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end
        if (arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rdata   = rd_word;
            s_d.rresp   = pmc_pkg::pmc_mapped(araddr) ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q         <= '0;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : pmc_axil

// >>> hw/pmc_wake.sv
// Wake message gate: decides whether a wake message leaves the port.
// Assumes all request inputs are synchronous to mclk; the own and forwarded requests are one cycle long.
module pmc_wake (
    input  wire logic                  mclk,    // Clock.
    input  wire logic                  srst,    // Synchronous reset.
    input  pmc_pkg::pmc_wake_req_s     req,     // Own and forwarded requests with gating.
    output logic                       msg      // Wake message pulse, registered.
);
    typedef struct packed {
        logic msg;
    } pmc_wake_state_s;

    pmc_wake_state_s s_q;
    pmc_wake_state_s s_d;

    assign msg = s_q.msg;

    // Nothing leaves in the deepest power state; own requests need the enable.
    always_comb begin
        s_d     = s_q;
        s_d.msg = !req.d3cold && ((req.own && req.enable) || req.fwd);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : pmc_wake

// >>> hw/pmc_top.sv
// Power management capability register pair for one switch port.
// Assumes a single clock, synchronous port resets and an AXI4-Lite master for configuration access.
//
// Operation
// - Capability identifier byte always reads one.
// - Next pointer reads zero on port A, 0x7C on ports B and C.
// - Capability version field reads two.
// - Wake clock flag, aux current field and bit 20 read zero.
// - Device specific init bit resets to zero and is lockable writable.
// - D1 and D2 support bits read zero.
// - Wake support field reads binary 11001.
// - No wake messages are forwarded in D3cold.
// - Power state resets to D0; writes select D0 or D3hot.
// - Wake enable gates own wake messages; resets to zero.
// - Port A holds wake enable and status at zero.
// - Wake enable on ports B and C survives hot reset.
// - Own wake sets status regardless of enable; sticky; write one clears.
// - Forwarded wake messages leave the status unchanged.
// - Data select, scale and data fields read zero.
// - Bus state support and bus power clock enable read zero.
module pmc_top #(
    parameter bit PORT_A = 1'b0                      // High for the upstream port.
) (
    input  wire logic                       mclk,          // Clock, 40 MHz.
    input  wire logic                       srst,          // Cold reset, clears sticky bits.
    input  wire logic                       hot_rst,       // Hot reset, keeps sticky bits.
    input  wire logic                       init_lock,     // High locks the device init bit.
    input  wire logic                       own_wake_req,  // Port originates a wake event.
    input  wire logic                       fwd_wake_req,  // Wake message passing through.
    input  wire logic                       d3cold_pin,    // Asynchronous D3cold indication.
    output logic                            wake_msg,      // Wake message pulse.
    output logic [1:0]                      power_state,   // Current power state field.
    output logic                            wake_status,   // Wake event status bit.
    input  wire logic [pmc_pkg::ADDR_W-1:0] s_awaddr,      // AXI write address.
    input  wire logic                       s_awvalid,     // AXI write address valid.
    output logic                            s_awready,     // AXI write address ready.
    input  wire logic [31:0]                s_wdata,       // AXI write data.
    input  wire logic [3:0]                 s_wstrb,       // AXI write strobes.
    input  wire logic                       s_wvalid,      // AXI write data valid.
    output logic                            s_wready,      // AXI write data ready.
    output logic [1:0]                      s_bresp,       // AXI write response.
    output logic                            s_bvalid,      // AXI write response valid.
    input  wire logic                       s_bready,      // AXI write response ready.
    input  wire logic [pmc_pkg::ADDR_W-1:0] s_araddr,      // AXI read address.
    input  wire logic                       s_arvalid,     // AXI read address valid.
    output logic                            s_arready,     // AXI read address ready.
    output logic [31:0]                     s_rdata,       // AXI read data.
    output logic [1:0]                      s_rresp,       // AXI read response.
    output logic                            s_rvalid,      // AXI read data valid.
    input  wire logic                       s_rready       // AXI read data ready.
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] power_state_field;
        logic       wake_event_enable;
        logic       wake_event_status;
        logic       device_specific_init;
        logic       d3cold_meta;
        logic       d3cold_sync;
    } pmc_regs_s;

    pmc_regs_s             r_q;
    pmc_regs_s             r_d;
    pmc_pkg::pmc_wr_s      wr;
    pmc_pkg::pmc_wake_req_s wreq;
    logic [31:0]           caps_word;
    logic [31:0]           csr_word;
    logic [31:0]           rd_word;
    logic                  own_event;

    // True for a committed write to one offset.
    function automatic logic hit(input pmc_pkg::pmc_wr_s w, input logic [7:0] ofs);
        return w.en && w.addr == ofs;
    endfunction : hit

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    always_comb begin
        caps_word                        = '0;
        caps_word[7:0]                   = pmc_pkg::CAP_ID_VAL;
        caps_word[15:8]                  = PORT_A ? pmc_pkg::NEXT_PTR_A : pmc_pkg::NEXT_PTR_BC;
        caps_word[18:16]                 = pmc_pkg::CAP_VERSION;
        caps_word[pmc_pkg::DEV_INIT_BIT] = r_q.device_specific_init;
        caps_word[31:27]                 = pmc_pkg::WAKE_SUPPORT;
        csr_word                         = '0;
        csr_word[1:0]                    = r_q.power_state_field;
        csr_word[pmc_pkg::WAKE_EN_BIT]   = r_q.wake_event_enable;
        csr_word[pmc_pkg::WAKE_STS_BIT]  = r_q.wake_event_status;
    end

    always_comb begin
        unique case (s_araddr)
            pmc_pkg::OFS_CAPS: rd_word = caps_word;
            pmc_pkg::OFS_CSR:  rd_word = csr_word;
            default:           rd_word = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus slave and wake gate
    // ----------------------------------------------------------------
    pmc_axil u_axil (
        .mclk    (mclk),
        .srst    (srst),
        .awaddr  (s_awaddr),
        .awvalid (s_awvalid),
        .awready (s_awready),
        .wdata   (s_wdata),
        .wstrb   (s_wstrb),
        .wvalid  (s_wvalid),
        .wready  (s_wready),
        .bresp   (s_bresp),
        .bvalid  (s_bvalid),
        .bready  (s_bready),
        .araddr  (s_araddr),
        .arvalid (s_arvalid),
        .arready (s_arready),
        .rdata   (s_rdata),
        .rresp   (s_rresp),
        .rvalid  (s_rvalid),
        .rready  (s_rready),
        .rd_word (rd_word),
        .wr      (wr)
    );

    assign own_event   = own_wake_req && !PORT_A;
    assign wreq.own    = own_event;
    assign wreq.fwd    = fwd_wake_req;
    assign wreq.enable = r_q.wake_event_enable;
    assign wreq.d3cold = r_q.d3cold_sync;

    pmc_wake u_wake (
        .mclk (mclk),
        .srst (srst),
        .req  (wreq),
        .msg  (wake_msg)
    );

    assign power_state = r_q.power_state_field;
    assign wake_status = r_q.wake_event_status;

    // ----------------------------------------------------------------
    // Register update
    // ----------------------------------------------------------------
    always_comb begin
        r_d             = r_q;
        r_d.d3cold_meta = d3cold_pin;
        r_d.d3cold_sync = r_q.d3cold_meta;
        // Only the writable bits are picked out of the write word.
        if (hit(wr, pmc_pkg::OFS_CSR)) begin
            if (wr.strb[0] && (wr.data[1:0] == pmc_pkg::POWER_STATE_FIELD_D0 || wr.data[1:0] == pmc_pkg::POWER_STATE_FIELD_D3HOT)) begin
                r_d.power_state_field = wr.data[1:0];
            end
            if (wr.strb[1] && !PORT_A) begin
                r_d.wake_event_enable = wr.data[pmc_pkg::WAKE_EN_BIT];
                if (wr.data[pmc_pkg::WAKE_STS_BIT]) begin
                    r_d.wake_event_status = 1'b0;
                end
            end
        end
        if (hit(wr, pmc_pkg::OFS_CAPS) && wr.strb[2] && !init_lock) begin
            r_d.device_specific_init = wr.data[pmc_pkg::DEV_INIT_BIT];
        end
        // A new event wins over a clear in the same cycle; forwarding never sets it.
        if (own_event) begin
            r_d.wake_event_status = 1'b1;
        end
        // Hot reset returns non-sticky fields only.
        if (hot_rst) begin
            r_d.power_state_field    = pmc_pkg::POWER_STATE_FIELD_D0;
            r_d.device_specific_init = pmc_pkg::DEV_INIT_RST;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            r_q                      <= '0;
            r_q.power_state_field    <= pmc_pkg::POWER_STATE_FIELD_D0;
            r_q.wake_event_enable    <= pmc_pkg::WAKE_EN_RST;
            r_q.wake_event_status    <= pmc_pkg::WAKE_STS_RST;
            r_q.device_specific_init <= pmc_pkg::DEV_INIT_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    property p_caps_fixed;
        s_arvalid && s_arready && s_araddr == pmc_pkg::OFS_CAPS |=>
            s_rvalid && s_rdata[7:0] == 8'h01 && s_rdata[18:16] == 3'h2 && s_rdata[31:27] == 5'h19;
    endproperty
    a_caps_fixed: assert property (p_caps_fixed) else $error("capability constant fields wrong");

    property p_next_ptr;
        s_arvalid && s_arready && s_araddr == pmc_pkg::OFS_CAPS |=>
            s_rdata[15:8] == (PORT_A ? 8'h00 : 8'h7c);
    endproperty
    a_next_ptr: assert property (p_next_ptr) else $error("next capability pointer wrong");

    property p_caps_zero;
        s_arvalid && s_arready && s_araddr == pmc_pkg::OFS_CAPS |=>
            s_rdata[20:19] == 2'h0 && s_rdata[26:22] == 5'h00;
    endproperty
    a_caps_zero: assert property (p_caps_zero) else $error("capability zero fields not zero");

    property p_csr_zero;
        s_arvalid && s_arready && s_araddr == pmc_pkg::OFS_CSR |=>
            s_rdata[31:16] == 16'h0000 && s_rdata[14:9] == 6'h00 && s_rdata[7:2] == 6'h00;
    endproperty
    a_csr_zero: assert property (p_csr_zero) else $error("control word reserved fields not zero");

    property p_d3cold_block;
        wake_msg |-> !$past(r_q.d3cold_sync);
    endproperty
    a_d3cold_block: assert property (p_d3cold_block) else $error("wake message sent in D3cold");

    property p_enable_gate;
        wake_msg |-> $past(fwd_wake_req) || $past(r_q.wake_event_enable);
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("own wake message without enable");

    property p_status_set;
        own_wake_req && !PORT_A |=> wake_status;
    endproperty
    a_status_set: assert property (p_status_set) else $error("wake status not set by own event");

    property p_fwd_no_status;
        fwd_wake_req && !own_wake_req && !wake_status |=> !wake_status;
    endproperty
    a_fwd_no_status: assert property (p_fwd_no_status) else $error("forwarded wake set status");

    property p_port_a_zero;
        PORT_A |-> !r_q.wake_event_enable && !wake_status;
    endproperty
    a_port_a_zero: assert property (p_port_a_zero) else $error("port A wake bits not zero");

    property p_sticky_hot;
        hot_rst && !wr.en |=> r_q.wake_event_enable == $past(r_q.wake_event_enable) && power_state == 2'h0;
    endproperty
    a_sticky_hot: assert property (p_sticky_hot) else $error("hot reset disturbed sticky enable");

    property p_power_state_field_legal;
        power_state == 2'h0 || power_state == 2'h3;
    endproperty
    a_power_state_field_legal: assert property (p_power_state_field_legal) else $error("reserved power state held");

    // Locked and reserved writes leave state alone.
    property p_init_lock;
        init_lock && !hot_rst |=>
            $stable(r_q.device_specific_init);
    endproperty
    a_init_lock: assert property (p_init_lock) else $error("locked init bit changed");

    property p_hot_init;
        hot_rst |=> !r_q.device_specific_init;
    endproperty
    a_hot_init: assert property (p_hot_init) else $error("hot reset kept init bit");

    property p_power_state_field_drop;
        hit(wr, pmc_pkg::OFS_CSR) && wr.strb[0] && wr.data[0] != wr.data[1] && !hot_rst |=>
            $stable(power_state);
    endproperty
    a_power_state_field_drop: assert property (p_power_state_field_drop) else $error("reserved power state taken");

    property p_status_clear;
        hit(wr, pmc_pkg::OFS_CSR) && wr.strb[1] && wr.data[pmc_pkg::WAKE_STS_BIT] && !own_event |=>
            !wake_status;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("wake status not cleared");

    // Messages that are allowed must leave.
    property p_own_msg;
        own_event && r_q.wake_event_enable && !r_q.d3cold_sync |=>
            wake_msg;
    endproperty
    a_own_msg: assert property (p_own_msg) else $error("own wake message missing");

    property p_fwd_msg;
        fwd_wake_req && !r_q.d3cold_sync |=>
            wake_msg;
    endproperty
    a_fwd_msg: assert property (p_fwd_msg) else $error("forwarded wake message missing");

    property p_csr_bus_zero;
        s_arvalid && s_arready && s_araddr == pmc_pkg::OFS_CSR |=>
            s_rdata[23:22] == 2'h0;
    endproperty
    a_csr_bus_zero: assert property (p_csr_bus_zero) else $error("bus support bits not zero");

    c_hot_sticky:  cover property (hot_rst && r_q.wake_event_enable ##1 r_q.wake_event_enable);
    c_d3_block:    cover property (fwd_wake_req && r_q.d3cold_sync);
    c_d3hot_write: cover property (hit(wr, pmc_pkg::OFS_CSR) ##1 power_state == 2'h3);
    c_status_set:  cover property (!wake_status ##1 wake_status);
    c_fwd_msg:     cover property (fwd_wake_req ##1 wake_msg);

endmodule : pmc_top

// >>> bench/pmc_host.sv
// Host model: configuration master on the AXI4-Lite register bus.
// Assumes the caller starts each access right after a rising edge.
module pmc_host (
    input  wire logic        mclk,    // Clock.
    output logic [7:0]       awaddr,  // Write address.
    output logic             awvalid, // Write address valid.
    input  wire logic        awready, // Write address ready.
    output logic [31:0]      wdata,   // Write data.
    output logic [3:0]       wstrb,   // Write strobes.
    output logic             wvalid,  // Write data valid.
    input  wire logic        wready,  // Write data ready.
    input  wire logic [1:0]  bresp,   // Write response.
    input  wire logic        bvalid,  // Write response valid.
    output logic             bready,  // Write response ready.
    output logic [7:0]       araddr,  // Read address.
    output logic             arvalid, // Read address valid.
    input  wire logic        arready, // Read address ready.
    input  wire logic [31:0] rdata,   // Read data.
    input  wire logic [1:0]  rresp,   // Read response.
    input  wire logic        rvalid,  // Read data valid.
    output logic             rready   // Read data ready.
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        @(posedge mclk);
        {awaddr, wdata, wstrb} <= {a, d, s};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        r = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        {d, r} = {rdata, rresp};
    endtask : rd
endmodule : pmc_host

// >>> bench/pmc_tb.sv
// Self-checking bench: port A (index 0) and port B (index 1), each with its own host model.
// Assumes the 40 MHz clock and the register map of the package.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] CAPS_B = 32'hc8027c01;
    localparam logic [31:0] CAPS_A = 32'hc8020001;
    logic mclk = 1'b0, srst = 1'b1, hot = 1'b0, lock = 1'b1, d3 = 1'b0;
    logic [1:0] own_r = '0, fwd_r = '0;
    wire [1:0] wm, ws, ps[2];
    int error_cnt = 0, checks_done = 0, cyc = 0;
    initial forever #12.5 mclk = ~mclk;
    for (genvar g = 0; g < 2; g++) begin : port
        logic [7:0] aw, ar;
        logic [31:0] wd, rdt;
        logic [3:0] st;
        logic [1:0] br, rr;
        logic awv, awr, wv, wr, bv, bry, arv, arr, rv, rry;
        pmc_top #(.PORT_A(g == 0)) uut (.mclk(mclk), .srst(srst), .hot_rst(hot), .init_lock(lock),
            .own_wake_req(own_r[g]), .fwd_wake_req(fwd_r[g]), .d3cold_pin(d3), .wake_msg(wm[g]),
            .power_state(ps[g]), .wake_status(ws[g]), .s_awaddr(aw), .s_awvalid(awv), .s_awready(awr),
            .s_wdata(wd), .s_wstrb(st), .s_wvalid(wv), .s_wready(wr), .s_bresp(br), .s_bvalid(bv),
            .s_bready(bry), .s_araddr(ar), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdt), .s_rresp(rr),
            .s_rvalid(rv), .s_rready(rry));
        pmc_host host (.mclk(mclk), .awaddr(aw), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(st),
            .wvalid(wv), .wready(wr), .bresp(br), .bvalid(bv), .bready(bry), .araddr(ar), .arvalid(arv),
            .arready(arr), .rdata(rdt), .rresp(rr), .rvalid(rv), .rready(rry));
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic axi_rd(input int p, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic [31:0] d;
        logic [1:0] r;
        if (p == 1) port[1].host.rd(a, d, r);
        else port[0].host.rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : axi_rd
    task automatic axi_wr(input int p, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er = 2'h0);
        logic [1:0] r;
        if (p == 1) port[1].host.wr(a, d, s, r);
        else port[0].host.wr(a, d, s, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : axi_wr
    task automatic hot_pulse;
        @(posedge mclk) hot <= 1'b1;
        @(posedge mclk) hot <= 1'b0;
    endtask : hot_pulse
    // Drives one request cycle and looks at the message and status one cycle later.
    task automatic pulse(input int p, input bit own, input logic em, input logic es);
        @(posedge mclk);
        if (own) own_r[p] <= 1'b1;
        else fwd_r[p] <= 1'b1;
        @(posedge mclk);
        own_r[p] <= 1'b0;
        fwd_r[p] <= 1'b0;
        #1;
        chk("wake_msg", em, wm[p]);
        chk("wake_status", es, ws[p]);
    endtask : pulse
    task automatic t_caps;
        axi_rd(1, 8'h70, CAPS_B);
        axi_rd(0, 8'h70, CAPS_A);
        axi_wr(1, 8'h70, 32'hffffffff, 4'hf);
        axi_rd(1, 8'h70, CAPS_B);
        @(posedge mclk) lock <= 1'b0;
        axi_wr(1, 8'h70, 32'hffffffff, 4'hf);
        axi_rd(1, 8'h70, CAPS_B | 32'h00200000);
        hot_pulse();
        axi_rd(1, 8'h70, CAPS_B);
        axi_rd(1, 8'h40, 32'h0, 2'h2);
        axi_wr(1, 8'h40, 32'h0, 4'hf, 2'h2);
    endtask : t_caps
    task automatic t_csr;
        axi_rd(1, 8'h74, 32'h0);
        axi_wr(1, 8'h74, 32'hffffffff, 4'hf);
        axi_rd(1, 8'h74, 32'h103);
        chk("power_state", 32'h3, ps[1]);
        for (int v = 1; v < 3; v++) begin
            axi_wr(1, 8'h74, v, 4'h1);
            axi_rd(1, 8'h74, 32'h103);
        end
        axi_wr(0, 8'h74, 32'hffffffff, 4'hf);
        axi_rd(0, 8'h74, 32'h3);
        chk("power_state", 32'h3, ps[0]);
    endtask : t_csr
    task automatic t_wake;
        pulse(1, 1, 1'b1, 1'b1);
        hot_pulse();
        axi_rd(1, 8'h74, 32'h8100);
        axi_wr(1, 8'h74, 32'h8000, 4'h2);
        axi_rd(1, 8'h74, 32'h0);
        pulse(1, 1, 1'b0, 1'b1);
        axi_wr(1, 8'h74, 32'h8000, 4'h2);
        pulse(1, 0, 1'b1, 1'b0);
        @(posedge mclk) d3 <= 1'b1;
        repeat (3) @(posedge mclk);
        pulse(1, 0, 1'b0, 1'b0);
        pulse(0, 1, 1'b0, 1'b0);
    endtask : t_wake
    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        t_caps();
        t_csr();
        t_wake();
        end_of_test();
    end
endmodule : testbench
